// [design/iel_cfg.svh]
// Address map, field layout and reset constants of the interrupt enable and latch block.
`ifndef IEL_CFG_SVH
`define IEL_CFG_SVH

`define IEL_ADDR_W 12
`define IEL_DATA_W 8
`define IEL_SRC_N 28
`define IEL_ID_W 5

`define IEL_ADDR_EN_LOW 12'h03a
`define IEL_ADDR_EN_MID 12'h03b
`define IEL_ADDR_EN_UPPER 12'h03c
`define IEL_ADDR_EN_TOP 12'h03d
`define IEL_ADDR_PEND_LOW 12'hfe0
`define IEL_ADDR_PEND_MID 12'hfe1
`define IEL_ADDR_PEND_UPPER 12'hfe2
`define IEL_ADDR_PEND_TOP 12'hfe3

`define IEL_EN_WMASK 28'hffffff1
`define IEL_PEND_CLRMASK 28'hffffff0
`define IEL_SRC_DRIVEN_MASK 28'hffcfff0
`define IEL_PEND_RMASK 28'hffffff8
`define IEL_REGS_PER_SET 4
`define IEL_EN_RESET 28'h0000000
`define IEL_PEND_RESET 28'h0000000

`define IEL_GLOBAL_BIT 0
`define IEL_WDT_BIT 3
`define IEL_FIRST_MASKABLE 4
`define IEL_LAST_MASKABLE 27

`define IEL_ID_SOFTWARE 5'h00
`define IEL_ID_UNDEF 5'h01
`define IEL_ID_WATCHDOG 5'h03
`define IEL_ID_NONE 5'h1f

`define IEL_EXT_N 4
`define IEL_EXT_POS {5'h08, 5'h14, 5'h13, 5'h12}
`define IEL_STACK_DEPTH 8

`endif

// [design/iel_pkg.sv]
// Shared types of the interrupt enable and latch block.
`include "iel_cfg.svh"

package iel_pkg;

  typedef logic [`IEL_ADDR_W-1:0] iel_addr_t;
  typedef logic [`IEL_DATA_W-1:0] iel_data_t;
  typedef logic [`IEL_ID_W-1:0] iel_id_t;
  typedef logic [`IEL_SRC_N-1:0] iel_vec_t;

  typedef enum logic [1:0] {
    IEL_KIND_NONE,
    IEL_KIND_NMI,
    IEL_KIND_MASKABLE
  } iel_kind_e;

endpackage : iel_pkg

// [design/iel_pin_if.sv]
// Carrier between the external pin filter and the controller core.
`timescale 1ns/100ps

interface iel_pin_if #(
  parameter int N = 4
);
  logic [N-1:0] raw;
  logic [N-1:0] rise;

  modport filter (input raw, output rise);
  modport core (output raw, input rise);
endinterface : iel_pin_if

// [design/iel_pin_filter.sv]
// Three-stage synchroniser with agreement filter and rising-edge pulse for interrupt pins.
`timescale 1ns/100ps

module iel_pin_filter #(
  parameter int N = 4
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  iel_pin_if.filter pins
);

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] level;
    logic [N-1:0] rise;
  } iel_filt_s;

  iel_filt_s st_reg;
  iel_filt_s st_next;

  // A change counts only once the second and third stages agree.
  always_comb
  begin
    st_next = st_reg;
    st_next.meta = pins.raw;
    st_next.s2 = st_reg.meta;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < N; i++)
    begin
      if (st_reg.s2[i] == st_reg.s3[i])
      begin
        st_next.level[i] = st_reg.s3[i];
      end
    end
    st_next.rise = st_next.level & ~st_reg.level;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pins.rise = st_reg.rise;

endmodule : iel_pin_filter

// [design/iel_top.sv]
// Maskable interrupt enable, pending latch and request selection logic.
`timescale 1ns/100ps
`include "iel_cfg.svh"

module iel_top #(
  parameter int STACK_DEPTH = `IEL_STACK_DEPTH
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire iel_pkg::iel_addr_t sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire iel_pkg::iel_data_t sfr_wdata_in,
  output iel_pkg::iel_data_t sfr_rdata_out,
  output logic sfr_rvalid_out,
  input wire iel_pkg::iel_vec_t src_req_in,
  input wire logic [`IEL_EXT_N-1:0] ext_int_in,
  input wire logic software_req_in,
  input wire logic undef_req_in,
  input wire logic watchdog_request_in,
  input wire logic unmask_all_instr_in,
  input wire logic mask_all_instr_in,
  input wire logic return_from_isr_in,
  input wire logic return_from_nmi_in,
  input wire logic accept_in,
  output logic irq_req_out,
  output iel_pkg::iel_id_t irq_id_out,
  output iel_pkg::iel_kind_e irq_kind_out,
  output logic global_enable_bit_out
);
  import iel_pkg::*;

  typedef struct packed {
    iel_vec_t enable;
    iel_vec_t pending;
    logic [STACK_DEPTH-1:0] stack;
    logic req;
    iel_id_t id;
    iel_kind_e kind;
    iel_data_t rdata;
    logic rvalid;
  } iel_state_s;

  localparam logic [`IEL_ID_W*`IEL_EXT_N-1:0] EXT_POS = `IEL_EXT_POS;

  iel_state_s st_reg;
  iel_state_s st_next;
  iel_vec_t set_vec;
  iel_vec_t wr_vec;
  logic [`IEL_REGS_PER_SET*`IEL_DATA_W-1:0] rd_en_vec;
  logic [`IEL_REGS_PER_SET*`IEL_DATA_W-1:0] rd_pend_vec;
  logic [1:0] wr_byte;
  logic wr_is_en;
  logic wr_is_pend;
  logic rd_hit;
  logic [1:0] rd_byte;
  logic rd_is_en;
  logic ret_any;

  iel_pin_if #(.N(`IEL_EXT_N)) pins ();

  assign pins.raw = ext_int_in;

  iel_pin_filter #(
    .N(`IEL_EXT_N)
  ) u_pin_filter (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .pins(pins)
  );

  // Collect request events; reserved positions have no source behind them.
  always_comb
  begin
    set_vec = src_req_in & `IEL_SRC_DRIVEN_MASK;
    set_vec[`IEL_WDT_BIT] = watchdog_request_in;
    for (int i = 0; i < `IEL_EXT_N; i++)
    begin
      if (pins.rise[i])
      begin
        set_vec[EXT_POS[i*`IEL_ID_W +: `IEL_ID_W]] = 1'b1;
      end
    end
  end

  // Address decode: each register holds one byte of the 28-bit vectors.
  always_comb
  begin
    wr_is_en = 1'b0;
    wr_is_pend = 1'b0;
    wr_byte = 2'h0;
    case (sfr_addr_in)
      `IEL_ADDR_EN_LOW: begin wr_is_en = 1'b1; wr_byte = 2'h0; end
      `IEL_ADDR_EN_MID: begin wr_is_en = 1'b1; wr_byte = 2'h1; end
      `IEL_ADDR_EN_UPPER: begin wr_is_en = 1'b1; wr_byte = 2'h2; end
      `IEL_ADDR_EN_TOP: begin wr_is_en = 1'b1; wr_byte = 2'h3; end
      `IEL_ADDR_PEND_LOW: begin wr_is_pend = 1'b1; wr_byte = 2'h0; end
      `IEL_ADDR_PEND_MID: begin wr_is_pend = 1'b1; wr_byte = 2'h1; end
      `IEL_ADDR_PEND_UPPER: begin wr_is_pend = 1'b1; wr_byte = 2'h2; end
      `IEL_ADDR_PEND_TOP: begin wr_is_pend = 1'b1; wr_byte = 2'h3; end
      default: begin wr_is_en = 1'b0; wr_is_pend = 1'b0; end
    endcase
    rd_hit = wr_is_en | wr_is_pend;
    rd_is_en = wr_is_en;
    rd_byte = wr_byte;
  end

  // Byte lane mask of the addressed register within the vectors.
  always_comb
  begin
    wr_vec = '0;
    for (int b = 0; b < `IEL_SRC_N; b++)
    begin
      if (b / `IEL_DATA_W == int'(wr_byte))
      begin
        wr_vec[b] = 1'b1;
      end
    end
  end

  // Both read vectors are padded to whole registers, so the top byte reads zero above bit 27.
  assign rd_en_vec = {{(`IEL_REGS_PER_SET*`IEL_DATA_W-`IEL_SRC_N){1'b0}},
    st_reg.enable & `IEL_EN_WMASK};
  assign rd_pend_vec = {{(`IEL_REGS_PER_SET*`IEL_DATA_W-`IEL_SRC_N){1'b0}},
    st_reg.pending & `IEL_PEND_RMASK};
  assign ret_any = return_from_isr_in | return_from_nmi_in;

  always_comb
  begin
    iel_vec_t wdata_vec;
    iel_vec_t en_sel;
    iel_vec_t clr_vec;
    iel_vec_t ready;
    logic found;
    wdata_vec = '0;
    en_sel = '0;
    clr_vec = '0;
    ready = '0;
    found = 1'b0;
    st_next = st_reg;

    // Repeat the written byte in every lane; wr_vec selects the same lane in both sets.
    for (int b = 0; b < `IEL_SRC_N; b++)
    begin
      wdata_vec[b] = sfr_wdata_in[b % `IEL_DATA_W];
    end

    // Enable registers, global bit included; unused bits are not stored.
    if (sfr_wr_in && wr_is_en)
    begin
      en_sel = wr_vec & `IEL_EN_WMASK;
      st_next.enable = (st_reg.enable & ~en_sel) | (wdata_vec & en_sel);
    end
    if (unmask_all_instr_in)
    begin
      st_next.enable[`IEL_GLOBAL_BIT] = 1'b1;
    end
    if (mask_all_instr_in)
    begin
      st_next.enable[`IEL_GLOBAL_BIT] = 1'b0;
    end

    // Return pops the saved global bit back into place.
    if (ret_any)
    begin
      st_next.enable[`IEL_GLOBAL_BIT] = st_reg.stack[0];
      st_next.stack = {1'b0, st_reg.stack[STACK_DEPTH-1:1]};
    end

    // Writing zero clears a latch, one leaves it; watchdog bit is untouched.
    if (sfr_wr_in && wr_is_pend)
    begin
      clr_vec = wr_vec & ~wdata_vec & `IEL_PEND_CLRMASK;
    end

    // Acceptance: save and clear the global bit, drop the served latch.
    if (accept_in && st_reg.req)
    begin
      st_next.stack = {st_reg.stack[STACK_DEPTH-2:0], st_reg.enable[`IEL_GLOBAL_BIT]};
      st_next.enable[`IEL_GLOBAL_BIT] = 1'b0;
      if (st_reg.id != `IEL_ID_SOFTWARE && st_reg.id != `IEL_ID_UNDEF)
      begin
        clr_vec[st_reg.id] = 1'b1;
      end
    end

    // A new request in the clearing cycle wins over the clear.
    st_next.pending = (st_reg.pending & ~clr_vec) | set_vec;

    // Pick the request to present; lower position ranks higher.
    ready = st_next.pending & st_next.enable
      & {`IEL_SRC_N{st_next.enable[`IEL_GLOBAL_BIT]}};
    st_next.req = 1'b0;
    st_next.id = `IEL_ID_NONE;
    st_next.kind = IEL_KIND_NONE;
    if (software_req_in)
    begin
      found = 1'b1;
      st_next.id = `IEL_ID_SOFTWARE;
    end
    else if (undef_req_in)
    begin
      found = 1'b1;
      st_next.id = `IEL_ID_UNDEF;
    end
    else if (st_next.pending[`IEL_WDT_BIT])
    begin
      found = 1'b1;
      st_next.id = `IEL_ID_WATCHDOG;
    end
    if (found)
    begin
      st_next.req = 1'b1;
      st_next.kind = IEL_KIND_NMI;
    end
    else
    begin
      for (int s = `IEL_LAST_MASKABLE; s >= `IEL_FIRST_MASKABLE; s--)
      begin
        if (ready[s])
        begin
          st_next.req = 1'b1;
          st_next.id = iel_id_t'(s);
          st_next.kind = IEL_KIND_MASKABLE;
        end
      end
    end
    // A request taken this cycle must not be shown again before its effects settle.
    if (accept_in && st_reg.req)
    begin
      st_next.req = 1'b0;
      st_next.id = `IEL_ID_NONE;
      st_next.kind = IEL_KIND_NONE;
    end

    // Registered read data; unmapped addresses read zero.
    st_next.rvalid = sfr_rd_in;
    st_next.rdata = '0;
    if (sfr_rd_in && rd_hit)
    begin
      if (rd_is_en)
      begin
        st_next.rdata = rd_en_vec[int'(rd_byte)*`IEL_DATA_W +: `IEL_DATA_W];
      end
      else
      begin
        st_next.rdata = rd_pend_vec[int'(rd_byte)*`IEL_DATA_W +: `IEL_DATA_W];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_reg <= '0;
      st_reg.enable <= `IEL_EN_RESET;
      st_reg.pending <= `IEL_PEND_RESET;
      st_reg.id <= `IEL_ID_NONE;
      st_reg.kind <= IEL_KIND_NONE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata_out = st_reg.rdata;
  assign sfr_rvalid_out = st_reg.rvalid;
  assign irq_req_out = st_reg.req;
  assign irq_id_out = st_reg.id;
  assign irq_kind_out = st_reg.kind;
  assign global_enable_bit_out = st_reg.enable[`IEL_GLOBAL_BIT];

endmodule : iel_top

// [bench/iel_cpu_model.sv]
// Behavioural core that takes presented requests and returns after a set delay.
`timescale 1ns/100ps
module iel_cpu_model (
  input logic clk_in,
  input logic en_in,
  input logic [3:0] lat_in,
  input logic irq_req_in,
  input iel_pkg::iel_kind_e kind_in,
  output logic accept_out = 1'b0,
  output logic ret_isr_out = 1'b0,
  output logic ret_nmi_out = 1'b0
);
  import iel_pkg::*;
  logic busy = 1'b0;
  logic nmi = 1'b0;
  logic [3:0] cnt = 4'h0;
  // Bit edits and latch clears are never made here, so nesting stays ordered.
  always @(posedge clk_in)
  begin
    accept_out <= 1'b0;
    ret_isr_out <= 1'b0;
    ret_nmi_out <= 1'b0;
    if (busy)
    begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h0)
      begin
        busy <= 1'b0;
        ret_nmi_out <= nmi;
        ret_isr_out <= !nmi;
      end
    end
    else if (en_in && irq_req_in && !accept_out)
    begin
      accept_out <= 1'b1;
      busy <= 1'b1;
      nmi <= (kind_in == IEL_KIND_NMI);
      cnt <= lat_in;
    end
  end
endmodule : iel_cpu_model

// [bench/iel_top_props.sv]
// Port checker of the interrupt enable and latch block.
`timescale 1ns/100ps
module iel_chk #(
  parameter int STACK_DEPTH = 8
) (
  input logic clk_in,
  input logic sys_rst_in,
  input logic sfr_rd_in,
  input iel_pkg::iel_data_t sfr_rdata_out,
  input logic sfr_rvalid_out,
  input logic software_req_in,
  input logic mask_all_instr_in,
  input logic return_from_isr_in,
  input logic return_from_nmi_in,
  input logic accept_in,
  input logic irq_req_out,
  input iel_pkg::iel_id_t irq_id_out,
  input iel_pkg::iel_kind_e irq_kind_out,
  input logic global_enable_bit_out
);
  import iel_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_take;
    accept_in && irq_req_out;
  endsequence
  sequence s_drop;
    !irq_req_out && !global_enable_bit_out;
  endsequence
  AST_RVALID: assert property (sfr_rd_in |=> sfr_rvalid_out)
    else $error("read not answered");
  AST_IDLE_BUS: assert property (!sfr_rd_in |=> !sfr_rvalid_out && sfr_rdata_out == 8'h00)
    else $error("read data without read");
  AST_TAKE: assert property (s_take |=> s_drop)
    else $error("accept left global bit or request");
  AST_MASK: assert property (mask_all_instr_in && !accept_in && !return_from_isr_in
    && !return_from_nmi_in |=> !global_enable_bit_out)
    else $error("mask did not clear global bit");
  AST_GATED: assert property (irq_kind_out == IEL_KIND_MASKABLE |-> global_enable_bit_out)
    else $error("maskable shown while masked");
  AST_NMI_ID: assert property (irq_kind_out == IEL_KIND_NMI |-> irq_id_out inside
    {5'h00, 5'h01, 5'h03})
    else $error("bad nmi id");
  AST_SW: assert property ($rose(software_req_in) && !accept_in && !$past(accept_in)
    |=> irq_req_out && irq_id_out == 5'h00)
    else $error("software request not shown");
  AST_NONE: assert property (!irq_req_out |-> irq_id_out == 5'h1f
    && irq_kind_out == IEL_KIND_NONE)
    else $error("id shown without request");
  AST_RST: assert property (disable iff (1'b0) sys_rst_in |=> s_drop and !sfr_rvalid_out)
    else $error("reset left outputs set");
endmodule : iel_chk
bind iel_top iel_chk #(.STACK_DEPTH(STACK_DEPTH)) i_chk (.clk_in, .sys_rst_in, .sfr_rd_in,
  .sfr_rdata_out, .sfr_rvalid_out, .software_req_in, .mask_all_instr_in, .return_from_isr_in,
  .return_from_nmi_in, .accept_in, .irq_req_out, .irq_id_out, .irq_kind_out,
  .global_enable_bit_out);

// [bench/testbench.sv]
// Self-checking bench of the interrupt enable and latch block.
`timescale 1ns/100ps
module testbench;
  import iel_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  iel_addr_t sfr_addr_in = 12'h000;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  iel_data_t sfr_wdata_in = 8'h00;
  iel_data_t sfr_rdata_out;
  logic sfr_rvalid_out, irq_req_out, gie, acc, rti, rtn;
  iel_vec_t src = '0;
  logic [3:0] ext = 4'h0;
  logic [3:0] lat = 4'h1;
  logic [2:0] pl = 3'h0;
  logic sw = 1'b0;
  logic ud = 1'b0;
  logic pen = 1'b0;
  iel_id_t irq_id_out;
  iel_kind_e irq_kind_out;
  int n_mismatch = 0;
  int num_checks = 0;
  iel_addr_t ad[8] = '{12'h03a, 12'h03b, 12'h03c, 12'h03d, 12'hfe0, 12'hfe1, 12'hfe2, 12'hfe3};
  iel_data_t ex[8] = '{8'hf0, 8'hff, 8'hff, 8'h07, 8'hf8, 8'hff, 8'hfc, 8'h0f};
  always #5 clk_in = ~clk_in;
  iel_top i_dut (.clk_in, .sys_rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
    .sfr_rdata_out, .sfr_rvalid_out, .src_req_in(src), .ext_int_in(ext), .software_req_in(sw),
    .undef_req_in(ud), .watchdog_request_in(pl[0]), .unmask_all_instr_in(pl[1]),
    .mask_all_instr_in(pl[2]), .return_from_isr_in(rti), .return_from_nmi_in(rtn),
    .accept_in(acc), .irq_req_out, .irq_id_out, .irq_kind_out, .global_enable_bit_out(gie));
  iel_cpu_model i_cpu (.clk_in, .en_in(pen), .lat_in(lat), .irq_req_in(irq_req_out),
    .kind_in(irq_kind_out), .accept_out(acc), .ret_isr_out(rti), .ret_nmi_out(rtn));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input iel_addr_t a, input iel_data_t d);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input iel_addr_t a, input iel_data_t e);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    @(negedge clk_in);
    chk($sformatf("reg %h", a), e, sfr_rdata_out);
    chk("rvalid", 8'h01, {7'h00, sfr_rvalid_out});
  endtask : rd
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_in);
    pl <= m;
    @(posedge clk_in);
    pl <= 3'h0;
  endtask : pulse
  task automatic take(input iel_id_t e);
    int n;
    for (n = 0; n < 300 && acc !== 1'b1; n++)
      @(negedge clk_in);
    if (n == 300)
    begin
      n_mismatch++;
      stop_test();
    end
    chk("irq id", {3'h0, e}, {3'h0, irq_id_out});
    chk("irq kind", (e < 5'h04) ? 8'h01 : 8'h02, {6'h00, irq_kind_out});
    @(negedge clk_in);
  endtask : take
  initial
  begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd(ad[i], 8'h00);
    rd(12'h040, 8'h00);
    $display("reset test done");
    wr(12'h03a, 8'hfe);
    wr(12'h03b, 8'hff);
    wr(12'h03c, 8'hff);
    wr(12'h03d, 8'hff);
    wr(12'h03d, 8'h07);
    for (int i = 4; i < 8; i++)
      wr(ad[i], 8'hff);
    for (int i = 4; i < 8; i++)
      rd(ad[i], 8'h00);
    @(posedge clk_in);
    src <= '1;
    ext <= 4'hf;
    pl <= 3'h1;
    @(posedge clk_in);
    src <= '0;
    pl <= 3'h0;
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
      rd(ad[i], ex[i]);
    chk("nmi id", 8'h03, {3'h0, irq_id_out});
    wr(12'hfe0, 8'h00);
    wr(12'hfe1, 8'hfe);
    rd(12'hfe0, 8'h08);
    rd(12'hfe1, 8'hfe);
    $display("register test done");
    pulse(3'h2);
    // The core starts only once the global bit is set, so the first accept saves a one.
    pen <= 1'b1;
    take(5'h03);
    for (int i = 9; i < 27; i++)
      if (i < 16 || i > 17)
        take(i[4:0]);
    repeat (10) @(negedge clk_in);
    chk("irq req", 8'h00, {7'h00, irq_req_out});
    rd(12'hfe3, 8'h08);
    rd(12'h03a, 8'hf1);
    chk("global bit", 8'h01, {7'h00, gie});
    $display("service test done");
    lat <= 4'h9;
    pulse(3'h4);
    @(posedge clk_in);
    sw <= 1'b1;
    take(5'h00);
    @(posedge clk_in);
    sw <= 1'b0;
    repeat (15) @(posedge clk_in);
    rd(12'h03a, 8'hf0);
    @(posedge clk_in);
    ud <= 1'b1;
    take(5'h01);
    @(posedge clk_in);
    ud <= 1'b0;
    repeat (15) @(posedge clk_in);
    rd(12'h03a, 8'hf0);
    chk("global bit", 8'h00, {7'h00, gie});
    $display("non-maskable test done");
    stop_test();
  end
endmodule : testbench
